/* hdl/flow_alarm_relay_consts.svh */
// Constants for the flow alarm, relay, conversion, auto-zero and backlight block.
// Overview of operation
// [R1] Flow above the high limit is a high flow alarm condition.
// [R2] The configuring party keeps each high limit strictly above its low limit.
// [R3] Alarm shows only after its condition lasts the action delay, 0 to 3600 s.
// [R4] A relay assigned to a detected alarm event is energized.
// [R5] Two independent relays, each with its own programmable event assignment.
// [R6] Each relay takes one of nine coded assignments; other codes act as none.
// [R7] A relay assigned to the totalizer activates when the total reaches the limit.
// [R8] A relay assigned to range activates while flow lies between the flow limits.
// [R9] Thirty-two built-in conversion factors serve every gas calibration.
// [R10] Factor selection is disabled (unity), table index 0 to 31, or user value.
// [R11] No conversion factor is applied when the unit is percent of full scale.
// [R12] Auto-zero starts only on a yes answer; a no answer aborts without change.
// [R13] During auto-zero the zero and sensor display refresh every four seconds.
// [R14] Auto-zero passes if the sensor is within 120 plus or minus 2, else fails.
// [R15] Actual flow is standard flow times (T+273.16)/294.26 times 14.7/P.
// [R16] No actual-flow correction when the unit is percent of full scale.
// [R17] With energy saving on, backlight goes off after 15 idle minutes.
// [R18] Any key press turns the backlight back on.
// [R19] Temperature limits are in Celsius; pressure limits in the selected unit.
// [R20] Alarms never latch; they clear as soon as the value returns.
// [R21] Flow below the low limit is a low flow alarm condition.
// [R22] Each alarm has a run enable; a stopped alarm is never indicated.
// [R23] The totalizer condition is true when the total equals the stop volume.
// [R24] The delay timer restarts from zero whenever the value returns inside limits.
// [R25] An unassigned relay stays off; an assigned one drops when its condition ends.
`ifndef FLOW_ALARM_RELAY_CONSTS_SVH
`define FLOW_ALARM_RELAY_CONSTS_SVH

// ****************************************
// Process variable and alarm indices
// ****************************************
`define PV_FLOW 0
`define PV_TEMP 1
`define PV_PRES 2
`define DIR_HI 0
`define DIR_LO 1
`define ACT_DELAY_MAX_S 12'hE10

// ****************************************
// Relay assignment codes
// ****************************************
`define RLY_NONE 4'h0
`define RLY_TOTAL 4'h1
`define RLY_HI_FLOW 4'h2
`define RLY_LO_FLOW 4'h3
`define RLY_RANGE 4'h4
`define RLY_HI_TEMP 4'h5
`define RLY_LO_TEMP 4'h6
`define RLY_HI_PRES 4'h7
`define RLY_LO_PRES 4'h8
`define RLY_CODES 4'h9

// ****************************************
// Conversion factor and actual flow
// ****************************************
`define KF_DISABLED 2'h0
`define KF_INTERNAL 2'h1
`define KF_USER 2'h2
`define KF_ONE 16'h1000
`define ABS_OFFSET_CC 18'h06AB4
`define STD_TEMP_CC 16'h72F2
`define STD_PRES_CP 11'h5BE

// ****************************************
// Auto-zero and backlight timing
// ****************************************
`define AZ_REFRESH_S 3'h4
`define AZ_NOMINAL 12'h078
`define AZ_TOL 12'h002
`define BL_TIMEOUT_MIN 15
`define BL_TIMEOUT_S (10'(`BL_TIMEOUT_MIN * 60))

`endif

/* hdl/flow_alarm_relay_pkg.sv */
// Types shared by the flow alarm and relay control block.
package flow_alarm_relay_pkg;

  typedef logic signed [15:0] pv_t;

  typedef struct packed {
    logic run;
    pv_t hi;
    pv_t lo;
    logic [11:0] delay;
  } alarm_cfg_t;

  typedef enum logic [2:0] {
    AZ_IDLE,
    AZ_ASK,
    AZ_RUN,
    AZ_PASS,
    AZ_FAIL
  } az_state_t;

endpackage

/* hdl/alarm_qualifier.sv */
// High and low limit check with action-delay qualification for one process value.
`timescale 1ns/1ps
`default_nettype none
`include "flow_alarm_relay_consts.svh"

module alarm_qualifier
  import flow_alarm_relay_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic sec_tick_i,
  input wire pv_t value_i,
  input wire alarm_cfg_t cfg_i,
  output logic [1:0] alarm_o
);

  logic [1:0] cond;
  logic [11:0] delay_eff;
  logic [1:0][11:0] cnt_reg;

  // A stopped alarm never sees a condition, so it can never be shown.
  assign cond[`DIR_HI] = cfg_i.run && (value_i > cfg_i.hi); // R1 R22
  assign cond[`DIR_LO] = cfg_i.run && (value_i < cfg_i.lo); // R21 R22
  assign delay_eff = (cfg_i.delay > `ACT_DELAY_MAX_S) ? `ACT_DELAY_MAX_S : cfg_i.delay;

  for (genvar g = 0; g < 2; g++) begin : g_dir
    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
        cnt_reg[g] <= 12'h000;
      end else if (!cond[g]) begin
        cnt_reg[g] <= 12'h000; // R24
      end else if (sec_tick_i && cnt_reg[g] < delay_eff) begin
        cnt_reg[g] <= cnt_reg[g] + 12'h001; // R3
      end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
        alarm_o[g] <= 1'b0;
      end else begin
        alarm_o[g] <= cond[g] && (cnt_reg[g] >= delay_eff); // R3 R20
      end
    end

    delay_met_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R3
      alarm_o[g] |-> $past(cnt_reg[g]) >= $past(delay_eff))
      else $error("alarm shown before its action delay ran out");
    no_latch_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R20
      $past(!cond[g]) |-> !alarm_o[g])
      else $error("alarm still shown after the value returned");
    timer_restart_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R24
      !cond[g] |=> cnt_reg[g] == 12'h000)
      else $error("delay timer did not restart");
  end

  stopped_quiet_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R22
    !cfg_i.run |=> alarm_o == 2'h0)
    else $error("stopped alarm was indicated");

endmodule

`default_nettype wire

/* hdl/flow_alarm_relay_control.sv */
// Alarm supervision, relay routing, flow conversion, auto-zero and backlight control.
`timescale 1ns/1ps
`default_nettype none
`include "flow_alarm_relay_consts.svh"

module flow_alarm_relay_control
  import flow_alarm_relay_pkg::*;
#(
  parameter int AZ_MAX_STEPS = 45
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic sec_tick_i,
  input wire logic key_i,
  input wire pv_t [2:0] pv_i,
  input wire alarm_cfg_t [2:0] alarm_cfg_i,
  input wire logic [31:0] total_i,
  input wire logic [31:0] stop_total_i,
  input wire logic [1:0][3:0] relay_sel_i,
  input wire logic [23:0] std_flow_i,
  input wire logic unit_pct_i,
  input wire logic [1:0] kf_mode_i,
  input wire logic [4:0] kf_index_i,
  input wire logic [15:0] kf_user_i,
  input wire logic kf_wr_i,
  input wire logic [4:0] kf_wr_index_i,
  input wire logic [15:0] kf_wr_value_i,
  input wire logic actual_mode_i,
  input wire logic [15:0] pres_psi_i,
  input wire logic az_start_i,
  input wire logic az_yes_i,
  input wire logic az_no_i,
  input wire logic az_ack_i,
  input wire logic [15:0] zero_i,
  input wire logic [11:0] sensor_i,
  input wire logic bl_enable_i,
  output logic [5:0] alarm_o,
  output logic [1:0] relay_o,
  output logic [23:0] flow_o,
  output logic az_busy_o,
  output logic az_refresh_o,
  output logic [15:0] az_zero_o,
  output logic [11:0] az_sensor_o,
  output logic az_pass_o,
  output logic az_fail_o,
  output logic backlight_o
);

  // ****************************************
  // Limit alarms
  // ****************************************
  // Temperature limits are compared in hundredths of a degree Celsius and
  // pressure limits in whatever unit pv_i carries; no unit conversion here.
  for (genvar p = 0; p < 3; p++) begin : g_pv
    alarm_qualifier u_qual (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .sec_tick_i(sec_tick_i),
      .value_i(pv_i[p]),
      .cfg_i(alarm_cfg_i[p]),
      .alarm_o(alarm_o[2*p +: 2])
    ); // R19
  end

  // ****************************************
  // Relay events
  // ****************************************
  logic range_reg;
  logic tot_reg;
  logic [8:0] ev;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      range_reg <= 1'b0;
    end else begin
      range_reg <= (pv_i[`PV_FLOW] >= alarm_cfg_i[`PV_FLOW].lo) &&
                   (pv_i[`PV_FLOW] <= alarm_cfg_i[`PV_FLOW].hi); // R8
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      tot_reg <= 1'b0;
    end else begin
      tot_reg <= (total_i == stop_total_i); // R23
    end
  end

  assign ev = {alarm_o[2*`PV_PRES + `DIR_LO], alarm_o[2*`PV_PRES + `DIR_HI],
               alarm_o[2*`PV_TEMP + `DIR_LO], alarm_o[2*`PV_TEMP + `DIR_HI],
               range_reg,
               alarm_o[2*`PV_FLOW + `DIR_LO], alarm_o[2*`PV_FLOW + `DIR_HI],
               tot_reg, 1'b0};

  // Each relay follows its event with no memory, so it drops the cycle after
  // the event clears. An illegal code is treated as no assignment.
  for (genvar r = 0; r < 2; r++) begin : g_relay
    always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
        relay_o[r] <= 1'b0;
      end else if (relay_sel_i[r] < `RLY_CODES) begin
        relay_o[r] <= ev[relay_sel_i[r]]; // R4 R5 R6 R7 R25
      end else begin
        relay_o[r] <= 1'b0; // R6
      end
    end

    hi_flow_route_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R4
      $past(relay_sel_i[r]) == `RLY_HI_FLOW |-> relay_o[r] == $past(alarm_o[0]))
      else $error("relay does not follow the high flow alarm");
    unassigned_off_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R25
      relay_sel_i[r] == `RLY_NONE |=> !relay_o[r])
      else $error("unassigned relay energized");
    illegal_code_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R6
      relay_sel_i[r] >= `RLY_CODES |=> !relay_o[r])
      else $error("relay energized on an illegal code");
    total_route_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R7
      $past(relay_sel_i[r]) == `RLY_TOTAL && $past(total_i == stop_total_i, 2)
      |-> relay_o[r])
      else $error("totalizer relay missed the stop volume");
    range_route_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R8
      $past(relay_sel_i[r]) == `RLY_RANGE && $past(pv_i[0] < alarm_cfg_i[0].lo, 2)
      |-> !relay_o[r])
      else $error("range relay on while flow below low limit");
  end

  // ****************************************
  // Conversion factor and actual flow
  // ****************************************
  logic [15:0] kf_tab [32];
  logic [15:0] kf_sel;
  logic [39:0] kf_prod;
  logic [23:0] flow_k_reg;
  logic signed [17:0] tabs_s;
  logic [16:0] tabs_u;
  logic [51:0] num;
  logic [30:0] den;
  logic [51:0] quot;
  logic correct;

  // The table powers up at unity; the factor values are loaded at start-up.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 32; i++) begin
        kf_tab[i] <= `KF_ONE;
      end
    end else if (kf_wr_i) begin
      kf_tab[kf_wr_index_i] <= kf_wr_value_i; // R9
    end
  end

  always_comb begin
    unique case (kf_mode_i)
      `KF_INTERNAL: kf_sel = kf_tab[kf_index_i]; // R10
      `KF_USER: kf_sel = kf_user_i; // R10
      default: kf_sel = `KF_ONE; // R10
    endcase
  end

  assign kf_prod = 40'(std_flow_i) * 40'(kf_sel);

  // Factors above unity can overflow; the result saturates instead of wrapping.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      flow_k_reg <= 24'h000000;
    end else if (unit_pct_i) begin
      flow_k_reg <= std_flow_i; // R11
    end else if (kf_prod[39:36] != 4'h0) begin
      flow_k_reg <= 24'hFFFFFF;
    end else begin
      flow_k_reg <= kf_prod[35:12];
    end
  end

  assign tabs_s = 18'(pv_i[`PV_TEMP]) + `ABS_OFFSET_CC;
  assign tabs_u = tabs_s[17] ? 17'h00000 : tabs_s[16:0];
  assign num = 52'(flow_k_reg) * 52'(tabs_u) * 52'(`STD_PRES_CP); // R15
  assign den = 31'(`STD_TEMP_CC) * 31'(pres_psi_i); // R15
  assign correct = actual_mode_i && !unit_pct_i && (pres_psi_i != 16'h0000); // R16
  assign quot = correct ? (num / 52'(den)) : 52'h0;

  // A zero pressure reading would divide by zero, so the factored flow passes uncorrected.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      flow_o <= 24'h000000;
    end else if (!correct) begin
      flow_o <= flow_k_reg; // R16
    end else if (quot[51:24] != 28'h0) begin
      flow_o <= 24'hFFFFFF;
    end else begin
      flow_o <= quot[23:0]; // R15
    end
  end

  unity_factor_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R10
    kf_mode_i == `KF_DISABLED && !unit_pct_i && std_flow_i[23:12] != 12'h000
    |=> flow_k_reg == $past(std_flow_i))
    else $error("disabled factor did not act as unity");
  pct_passthru_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R11 R16
    $past(unit_pct_i) && unit_pct_i |=> flow_o == $past(std_flow_i, 2))
    else $error("percent full scale flow was altered");

  // ****************************************
  // Auto-zero sequence
  // ****************************************
  az_state_t az_state_reg;
  az_state_t az_state_next;
  logic [2:0] az_sec_reg;
  logic [7:0] az_step_reg;
  logic az_tick_due;
  logic az_in_window;

  assign az_tick_due = (az_state_reg == AZ_RUN) && sec_tick_i &&
                       (az_sec_reg == `AZ_REFRESH_S - 3'h1);
  assign az_in_window = (sensor_i >= `AZ_NOMINAL - `AZ_TOL) &&
                        (sensor_i <= `AZ_NOMINAL + `AZ_TOL); // R14

  always_comb begin
    az_state_next = az_state_reg;
    unique case (az_state_reg)
      AZ_IDLE: if (az_start_i) az_state_next = AZ_ASK;
      AZ_ASK: begin
        if (az_yes_i) begin
          az_state_next = AZ_RUN; // R12
        end else if (az_no_i) begin
          az_state_next = AZ_IDLE; // R12
        end
      end
      AZ_RUN: begin
        if (az_tick_due && az_in_window) begin
          az_state_next = AZ_PASS; // R14
        end else if (az_tick_due && az_step_reg == 8'(AZ_MAX_STEPS - 1)) begin
          az_state_next = AZ_FAIL; // R14
        end
      end
      AZ_PASS, AZ_FAIL: if (az_ack_i) az_state_next = AZ_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      az_state_reg <= AZ_IDLE;
      az_busy_o <= 1'b0;
      az_pass_o <= 1'b0;
      az_fail_o <= 1'b0;
    end else begin
      az_state_reg <= az_state_next;
      az_busy_o <= (az_state_next == AZ_RUN);
      az_pass_o <= (az_state_next == AZ_PASS);
      az_fail_o <= (az_state_next == AZ_FAIL);
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      az_sec_reg <= 3'h0;
      az_step_reg <= 8'h00;
    end else if (az_state_reg != AZ_RUN) begin
      az_sec_reg <= 3'h0;
      az_step_reg <= 8'h00;
    end else if (az_tick_due) begin
      az_sec_reg <= 3'h0;
      az_step_reg <= az_step_reg + 8'h01;
    end else if (sec_tick_i) begin
      az_sec_reg <= az_sec_reg + 3'h1;
    end
  end

  // The display values are held until the next refresh, so the final screen
  // shows the reading that decided the outcome.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      az_refresh_o <= 1'b0;
      az_zero_o <= 16'h0000;
      az_sensor_o <= 12'h000;
    end else begin
      az_refresh_o <= az_tick_due; // R13
      if (az_tick_due) begin
        az_zero_o <= zero_i; // R13
        az_sensor_o <= sensor_i; // R13
      end
    end
  end

  abort_on_no_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R12
    az_state_reg == AZ_ASK && az_no_i && !az_yes_i |=> az_state_reg == AZ_IDLE && !az_busy_o)
    else $error("negative answer did not abort auto-zero");
  refresh_period_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R13
    az_refresh_o |-> $past(sec_tick_i) && $past(az_sec_reg) == 3'h3)
    else $error("auto-zero refresh off its four second period");
  pass_window_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R14
    $rose(az_pass_o) |-> az_sensor_o >= 12'h076 && az_sensor_o <= 12'h07A)
    else $error("auto-zero passed outside the window");
  fail_window_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R14
    $rose(az_fail_o) |-> az_sensor_o < 12'h076 || az_sensor_o > 12'h07A)
    else $error("auto-zero failed inside the window");

  // ****************************************
  // Keypad and backlight
  // ****************************************
  logic key_meta_reg;
  logic key_s2_reg;
  logic key_s3_reg;
  logic key_stable_reg;
  logic key_press;
  logic [9:0] bl_idle_reg;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      key_meta_reg <= 1'b0;
      key_s2_reg <= 1'b0;
      key_s3_reg <= 1'b0;
    end else begin
      key_meta_reg <= key_i;
      key_s2_reg <= key_meta_reg;
      key_s3_reg <= key_s2_reg;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      key_stable_reg <= 1'b0;
    end else if (key_s2_reg == key_s3_reg) begin
      key_stable_reg <= key_s3_reg;
    end
  end

  assign key_press = key_s2_reg && key_s3_reg && !key_stable_reg;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      bl_idle_reg <= 10'h000;
      backlight_o <= 1'b1;
    end else if (key_press || !bl_enable_i) begin
      bl_idle_reg <= 10'h000;
      backlight_o <= 1'b1; // R18
    end else if (sec_tick_i && bl_idle_reg == `BL_TIMEOUT_S - 10'h001) begin
      bl_idle_reg <= bl_idle_reg + 10'h001;
      backlight_o <= 1'b0; // R17
    end else if (sec_tick_i && bl_idle_reg < `BL_TIMEOUT_S) begin
      bl_idle_reg <= bl_idle_reg + 10'h001;
    end
  end

  key_wakes_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R18
    key_press |=> backlight_o)
    else $error("key press did not restore the backlight");
  early_off_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R17
    $fell(backlight_o) |-> $past(bl_idle_reg) == 10'h383 && $past(bl_enable_i))
    else $error("backlight turned off before the idle timeout");

endmodule

`default_nettype wire

/* dv/relay_load.sv */
// Behavioural load switched by the two relay contacts.
`timescale 1ns/1ps
`default_nettype none

module relay_load (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [1:0] coil_i,
  output logic [1:0] contact_o
);
  // ****************************************
  // Contact mechanics
  // ****************************************
  // The contact settles one clock after its coil changes, standing in for armature travel,
  // so a check on the contact sees the value the coil held at the previous clock edge.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      contact_o <= 2'h0;
    end else begin
      contact_o <= coil_i;
    end
  end
endmodule

`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the flow alarm and relay control block.
`timescale 1ns/1ps
`default_nettype none
`include "flow_alarm_relay_consts.svh"

`define CHK(name, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("FAIL %s expected %0h seen %0h", name, exp, got); \
    end \
  end

module testbench
  import flow_alarm_relay_pkg::*;
;
  localparam int LIMIT = 20000;
  typedef struct {int kind; logic [23:0] exp;} note_t;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic tick = 1'b0;
  logic key = 1'b0;
  pv_t [2:0] pv;
  alarm_cfg_t [2:0] cfg;
  logic [31:0] total, stop;
  logic [1:0][3:0] sel;
  logic [23:0] std, flow;
  logic pct, actual, kf_wr, bl_en, busy, refresh, pass, fail, bl;
  logic [1:0] kmode, relay, contact;
  logic [15:0] pres, zero, az_zero;
  logic [11:0] sensor, az_sensor;
  logic [3:0] az_cmd;
  logic [5:0] alarm;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n_ref = 0;
  int lo_lim[3] = '{100, 1000, 100};
  int hi_lim[3] = '{1000, 5000, 1000};
  note_t notes[$];

  flow_alarm_relay_control #(.AZ_MAX_STEPS(3)) uut (
    .mclk_i(mclk), .reset_i(reset), .sec_tick_i(tick), .key_i(key), .pv_i(pv),
    .alarm_cfg_i(cfg), .total_i(total), .stop_total_i(stop), .relay_sel_i(sel),
    .std_flow_i(std), .unit_pct_i(pct), .kf_mode_i(kmode), .kf_index_i(5'h05),
    .kf_user_i(16'h2000), .kf_wr_i(kf_wr), .kf_wr_index_i(5'h05), .kf_wr_value_i(16'h0800),
    .actual_mode_i(actual), .pres_psi_i(pres), .az_start_i(az_cmd[0]), .az_yes_i(az_cmd[1]),
    .az_no_i(az_cmd[2]), .az_ack_i(az_cmd[3]), .zero_i(zero), .sensor_i(sensor),
    .bl_enable_i(bl_en), .alarm_o(alarm), .relay_o(relay), .flow_o(flow), .az_busy_o(busy),
    .az_refresh_o(refresh), .az_zero_o(az_zero), .az_sensor_o(az_sensor), .az_pass_o(pass),
    .az_fail_o(fail), .backlight_o(bl)
  );

  relay_load load (
    .mclk_i(mclk), .reset_i(reset), .coil_i(relay), .contact_o(contact)
  );

  // ****************************************
  // Clock, timeout and result watcher
  // ****************************************
  initial begin
    forever #10 mclk = ~mclk;
  end

  always @(negedge mclk) begin
    cyc++;
    n_ref += int'(refresh === 1'b1);
    if (cyc == LIMIT) begin
      n_errors++;
      complete_run();
    end
  end

  // Notes are taken just after the falling edge, once the driver has queued them.
  always @(negedge mclk) begin
    note_t n;
    #1;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.kind)
        0: `CHK("alarm", n.exp[5:0], alarm)
        1: `CHK("contact", n.exp[1:0], contact)
        2: `CHK("flow", n.exp, flow)
        3: `CHK("az_status", n.exp[2:0], {fail, pass, busy})
        4: `CHK("az_zero", n.exp[15:0], az_zero)
        5: `CHK("az_sensor", n.exp[11:0], az_sensor)
        6: `CHK("refreshes", n.exp, 24'(n_ref))
        default: `CHK("backlight", n.exp[0], bl)
      endcase
    end
  end

  // ****************************************
  // Driver tasks
  // ****************************************
  task automatic note(input int kind, input logic [23:0] exp);
    notes.push_back('{kind, exp});
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      tick = 1'b1;
      @(negedge mclk);
      tick = 1'b0;
      @(negedge mclk);
    end
  endtask

  task automatic azc(input int b);
    az_cmd[b] = 1'b1;
    @(negedge mclk);
    az_cmd = 4'h0;
    cycles(2);
  endtask

  function automatic logic ev(input logic [3:0] c, input logic [5:0] a, input logic r,
                              input logic t);
    case (c)
      `RLY_TOTAL: return t;
      `RLY_HI_FLOW: return a[0];
      `RLY_LO_FLOW: return a[1];
      `RLY_RANGE: return r;
      `RLY_HI_TEMP: return a[2];
      `RLY_LO_TEMP: return a[3];
      `RLY_HI_PRES: return a[4];
      `RLY_LO_PRES: return a[5];
      default: return 1'b0;
    endcase
  endfunction

  // Limits stay fixed with high above low; values land on both sides of each boundary.
  task automatic rnd_alarm();
    logic [5:0] ea;
    logic rng, tot;
    int v[3];
    for (int p = 0; p < 3; p++) begin
      case ($urandom % 5)
        0: v[p] = lo_lim[p] - 1;
        1: v[p] = lo_lim[p];
        2: v[p] = hi_lim[p];
        3: v[p] = hi_lim[p] + 1;
        default: v[p] = (lo_lim[p] + hi_lim[p]) / 2;
      endcase
      pv[p] = 16'(v[p]);
      cfg[p].run = ($urandom % 4) != 0;
      ea[2*p] = cfg[p].run && v[p] > hi_lim[p];
      ea[2*p+1] = cfg[p].run && v[p] < lo_lim[p];
    end
    rng = v[0] >= lo_lim[0] && v[0] <= hi_lim[0];
    stop = $urandom;
    total = stop + 32'($urandom % 2);
    tot = total == stop;
    sel[0] = 4'($urandom);
    sel[1] = 4'($urandom);
    cycles(4);
    note(0, 24'(ea));
    note(1, {22'h0, ev(sel[1], ea, rng, tot), ev(sel[0], ea, rng, tot)});
  endtask

  task automatic fl(input logic p, input logic [1:0] m, input logic a, input logic [15:0] pr,
                    input int num, input int den);
    std = 24'($urandom & 32'h000FFFFF);
    pct = p;
    kmode = m;
    actual = a;
    pres = pr;
    cycles(4);
    note(2, 24'(std * num / den));
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(66751));
    sel = '0;
    total = 32'h0;
    stop = 32'h5;
    std = 24'h0;
    pct = 1'b0;
    kmode = 2'h0;
    actual = 1'b0;
    pres = 16'h05BE;
    zero = 16'h0753;
    sensor = 12'h076;
    az_cmd = 4'h0;
    kf_wr = 1'b0;
    bl_en = 1'b0;
    for (int p = 0; p < 3; p++) begin
      cfg[p] = '{run: 1'b1, hi: 16'(hi_lim[p]), lo: 16'(lo_lim[p]), delay: 12'h000};
      pv[p] = 16'((lo_lim[p] + hi_lim[p]) / 2);
    end
    cycles(3);
    reset = 1'b0;
    cycles(2);
    note(1, 24'h0);
    cfg[0].delay = 12'h002;
    sel[0] = `RLY_HI_FLOW;
    pv[0] = 16'sh044C;
    ticks(1);
    pv[0] = 16'sh01F4;
    cycles(2);
    pv[0] = 16'sh044C;
    ticks(1);
    cycles(3);
    note(0, 24'h0);
    ticks(1);
    cycles(3);
    note(0, 24'h1);
    note(1, 24'h1);
    pv[0] = 16'sh01F4;
    cycles(4);
    note(0, 24'h0);
    note(1, 24'h0);
    cfg[0].delay = 12'h000;
    repeat (48) rnd_alarm();
    for (int p = 0; p < 3; p++) begin
      cfg[p].run = 1'b1;
      pv[p] = 16'((lo_lim[p] + hi_lim[p]) / 2);
    end
    pv[1] = 16'sh083E;
    kf_wr = 1'b1;
    @(negedge mclk);
    kf_wr = 1'b0;
    fl(1'b1, 2'h2, 1'b1, 16'h02DF, 1, 1);
    fl(1'b0, 2'h0, 1'b0, 16'h05BE, 1, 1);
    fl(1'b0, 2'h2, 1'b0, 16'h05BE, 2, 1);
    fl(1'b0, 2'h1, 1'b0, 16'h05BE, 1, 2);
    fl(1'b0, 2'h0, 1'b1, 16'h05BE, 1, 1);
    fl(1'b0, 2'h0, 1'b1, 16'h02DF, 2, 1);
    fl(1'b0, 2'h3, 1'b0, 16'h05BE, 1, 1);
    fl(1'b0, 2'h0, 1'b1, 16'h0000, 1, 1);
    azc(0);
    azc(2);
    azc(1);
    note(3, 24'h0);
    azc(0);
    azc(1);
    note(3, 24'h1);
    ticks(3);
    cycles(2);
    note(6, 24'h0);
    ticks(1);
    cycles(2);
    note(6, 24'h1);
    note(4, 24'h000753);
    note(5, 24'h000076);
    note(3, 24'h2);
    azc(3);
    note(3, 24'h0);
    sensor = 12'h07B;
    azc(0);
    azc(1);
    ticks(8);
    cycles(2);
    note(3, 24'h1);
    ticks(4);
    cycles(2);
    note(6, 24'h4);
    note(3, 24'h4);
    azc(3);
    bl_en = 1'b1;
    ticks(899);
    cycles(2);
    note(7, 24'h1);
    ticks(1);
    cycles(2);
    note(7, 24'h0);
    key = 1'b1;
    cycles(8);
    note(7, 24'h1);
    key = 1'b0;
    cycles(4);
    complete_run();
  end
endmodule

`default_nettype wire
